// ===== shared/input_map_pkg.sv
// Constants, codes and register map of the input function mapper.
// Function
// - Each terminal takes its selected function role.
// - Per-terminal polarity inverts sensed level when low.
// - Polarity code 00 active high, 01 low.
// - Code 00 active: run forward, else stop.
// - Code 01 active: run reverse, else stop.
// - Codes 02-05 give speed-select bits 0-3.
// - Code 06 active: jog run, else stop.
// - Code 07 active requests DC braking on deceleration.
// - Code 08 active selects second motor set.
// - Motor set changes only while stopped.
// - Code 09 active selects second-stage ramps.
// - Code 11 active turns output off, coasting.
package input_map_pkg;

    // Function codes held in the function-select registers.
    localparam logic [7:0] FN_FORWARD_RUN   = 8'h00;
    localparam logic [7:0] FN_REVERSE_RUN   = 8'h01;
    localparam logic [7:0] FN_SPEED_BIT0    = 8'h02;
    localparam logic [7:0] FN_SPEED_BIT3    = 8'h05;
    localparam logic [7:0] FN_JOG_RUN       = 8'h06;
    localparam logic [7:0] FN_DC_BRAKE      = 8'h07;
    localparam logic [7:0] FN_MOTOR2_SELECT = 8'h08;
    localparam logic [7:0] FN_SECOND_RAMP   = 8'h09;
    localparam logic [7:0] FN_COAST_STOP    = 8'h0b;

    // Polarity codes held in the polarity registers.
    localparam logic [1:0] POL_NORMALLY_OPEN   = 2'h0;
    localparam logic [1:0] POL_NORMALLY_CLOSED = 2'h1;

    // Byte offsets: function selects, polarities, then status.
    localparam logic [7:0] OFS_FUNC_BASE = 8'h00;
    localparam logic [7:0] OFS_POL_BASE  = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h40;
    localparam int         MAX_TERM      = 8;

    // Status field positions.
    localparam int ST_LEVEL_LSB  = 0;
    localparam int ST_ACTIVE_LSB = 8;
    localparam int ST_SPEED_LSB  = 16;
    localparam int ST_FWD_BIT    = 20;
    localparam int ST_REV_BIT    = 21;
    localparam int ST_JOG_BIT    = 22;
    localparam int ST_BRAKE_BIT  = 23;
    localparam int ST_MOTOR2_BIT = 24;
    localparam int ST_RAMP_BIT   = 25;
    localparam int ST_COAST_BIT  = 26;
    localparam int ST_RUN_BIT    = 27;

    // Reset values of the function selects, terminal 1 first.
    localparam logic [7:0] RST_FUNC [MAX_TERM] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h00, 8'h00, 8'h00
    };
    localparam logic [1:0] RST_POL = POL_NORMALLY_OPEN;

    // Bus answer sequencer, Gray coded.
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h0,
        BUS_ANSWER = 2'h1
    } bus_state_t;

endpackage

// ===== hdl/pin_filter.sv
// Three-stage pin synchroniser with an agreement filter.
`timescale 1ns/10ps
module pin_filter
    import input_map_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic srst,
    // Pin and its settled level.
    input  wire logic pin,
    output logic      level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // The first stage feeds only the second, so metastability stays put.
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once the two late stages agree.
    always_ff @(posedge clk) begin
        if (srst) begin
            level <= INIT;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end

    property p_agree;
        @(posedge clk) disable iff (srst)
        $changed(level) |-> $past(s2_r) == $past(s3_r);
    endproperty
    a_agree: assert property (p_agree)
        else $error("Level moved without stage agreement.");

endmodule

// ===== hdl/input_function_mapper.sv
// Maps five logic input terminals onto drive functions.
`timescale 1ns/10ps
module input_function_mapper
    import input_map_pkg::*;
#(
    parameter int N_TERM = 5
) (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        SRST,
    // Avalon-MM register slave.
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Terminal pins and motor feedback.
    input  wire logic [N_TERM-1:0] TERM_IN,
    input  wire logic        MOTOR_RUNNING,
    // Drive commands.
    output logic             RUN_STATE,
    output logic             FORWARD_RUN,
    output logic             REVERSE_RUN,
    output logic             JOG_RUN,
    output logic [3:0]       SPEED_SEL,
    output logic             DC_BRAKE_REQUEST,
    output logic             MOTOR2_SELECT,
    output logic             SECOND_RAMP_SELECT,
    output logic             COAST_STOP
);

    // The map has room for eight terminals only.
    if (N_TERM < 1 || N_TERM > MAX_TERM) begin : g_bad_count
        $error("N_TERM must lie between 1 and 8.");
    end

    logic [7:0]        func_r [N_TERM];
    logic [1:0]        pol_r  [N_TERM];
    logic [N_TERM-1:0] level;
    logic [N_TERM-1:0] act;
    bus_state_t        bus_r;
    bus_state_t        bus_nxt;
    logic              req;
    logic              wr_take;
    logic [5:0]        word;
    logic [31:0]       status;
    logic [31:0]       rd_nxt;
    logic              fwd_req;
    logic              rev_req;
    logic              jog_req;
    logic [3:0]        speed_nxt;
    logic              brake_req;
    logic              motor2_req;
    logic              ramp_req;
    logic              coast_req;
    logic              any_known;

    // Each pin is settled on its own before the polarity is applied.
    for (genvar t = 0; t < N_TERM; t++) begin : g_term
        pin_filter #(
            .INIT (1'b0)
        ) u_filter (
            .clk   (CLK),
            .srst  (SRST),
            .pin   (TERM_IN[t]),
            .level (level[t])
        );
        // A normally closed terminal counts as active when low.
        assign act[t] = (pol_r[t] == POL_NORMALLY_CLOSED) ?
                        ~level[t] : level[t];
    end

    // One wait cycle, then the answer; the request then must drop.
    assign req             = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req && (bus_r == BUS_IDLE);
    assign wr_take         = AVS_WRITE && (bus_r == BUS_ANSWER);
    assign word            = AVS_ADDRESS[7:2];

    // Bus sequencer next state.
    always_comb begin
        case (bus_r)
            BUS_IDLE:   bus_nxt = req ? BUS_ANSWER : BUS_IDLE;
            BUS_ANSWER: bus_nxt = BUS_IDLE;
            default:    bus_nxt = BUS_IDLE;
        endcase
    end

    // Bus sequencer state.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bus_r <= BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // Settings are written on byte lane zero only; other lanes are empty.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < N_TERM; i++) begin
                func_r[i] <= RST_FUNC[i];
                pol_r[i]  <= RST_POL;
            end
        end else if (wr_take && AVS_BYTEENABLE[0]) begin
            for (int i = 0; i < N_TERM; i++) begin
                if (word == 6'(OFS_FUNC_BASE[7:2] + 6'(i))) begin
                    func_r[i] <= AVS_WRITEDATA[7:0];
                end
                if (word == 6'(OFS_POL_BASE[7:2] + 6'(i))) begin
                    pol_r[i] <= AVS_WRITEDATA[1:0];
                end
            end
        end
    end

    // Status gathers pins, active levels and the command outputs.
    always_comb begin
        status = 32'h0;
        status[ST_LEVEL_LSB  +: N_TERM] = level;
        status[ST_ACTIVE_LSB +: N_TERM] = act;
        status[ST_SPEED_LSB  +: 4]      = SPEED_SEL;
        status[ST_FWD_BIT]    = FORWARD_RUN;
        status[ST_REV_BIT]    = REVERSE_RUN;
        status[ST_JOG_BIT]    = JOG_RUN;
        status[ST_BRAKE_BIT]  = DC_BRAKE_REQUEST;
        status[ST_MOTOR2_BIT] = MOTOR2_SELECT;
        status[ST_RAMP_BIT]   = SECOND_RAMP_SELECT;
        status[ST_COAST_BIT]  = COAST_STOP;
        status[ST_RUN_BIT]    = RUN_STATE;
    end

    // Read mux; an unmapped word reads as zero.
    always_comb begin
        rd_nxt = 32'h0;
        if (word == OFS_STATUS[7:2]) begin
            rd_nxt = status;
        end
        for (int i = 0; i < N_TERM; i++) begin
            if (word == 6'(OFS_FUNC_BASE[7:2] + 6'(i))) begin
                rd_nxt = {24'h0, func_r[i]};
            end
            if (word == 6'(OFS_POL_BASE[7:2] + 6'(i))) begin
                rd_nxt = {30'h0, pol_r[i]};
            end
        end
    end

    // Read data is caught during the wait cycle and stands afterwards.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ && bus_r == BUS_IDLE) begin
            AVS_READDATA <= rd_nxt;
        end
    end

    // Functions are gathered over all terminals; unknown codes fall out.
    always_comb begin
        fwd_req    = 1'b0;
        rev_req    = 1'b0;
        jog_req    = 1'b0;
        speed_nxt  = 4'h0;
        brake_req  = 1'b0;
        motor2_req = 1'b0;
        ramp_req   = 1'b0;
        coast_req  = 1'b0;
        any_known  = 1'b0;
        for (int i = 0; i < N_TERM; i++) begin
            if (act[i]) begin
                any_known = any_known || func_r[i] <= FN_SECOND_RAMP ||
                            func_r[i] == FN_COAST_STOP;
                case (func_r[i])
                    FN_FORWARD_RUN:   fwd_req    = 1'b1;
                    FN_REVERSE_RUN:   rev_req    = 1'b1;
                    FN_JOG_RUN:       jog_req    = 1'b1;
                    FN_DC_BRAKE:      brake_req  = 1'b1;
                    FN_MOTOR2_SELECT: motor2_req = 1'b1;
                    FN_SECOND_RAMP:   ramp_req   = 1'b1;
                    FN_COAST_STOP:    coast_req  = 1'b1;
                    default: begin
                        // Speed bits sit on four adjacent codes.
                        if (func_r[i] >= FN_SPEED_BIT0 &&
                            func_r[i] <= FN_SPEED_BIT3) begin
                            speed_nxt[2'(func_r[i] - FN_SPEED_BIT0)] =
                                1'b1;
                        end
                        // Any other code leaves the drive untouched.
                    end
                endcase
            end
        end
    end

    // Run commands: opposite directions together count as stop, and
    // jog only runs when neither direction is asked for.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FORWARD_RUN <= 1'b0;
            REVERSE_RUN <= 1'b0;
            JOG_RUN     <= 1'b0;
            RUN_STATE   <= 1'b0;
        end else begin
            FORWARD_RUN <= fwd_req && !rev_req;
            REVERSE_RUN <= rev_req && !fwd_req;
            JOG_RUN     <= jog_req && !fwd_req && !rev_req;
            RUN_STATE   <= (fwd_req ^ rev_req) ||
                           (jog_req && !fwd_req && !rev_req);
        end
    end

    // Level functions follow their terminals directly.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SPEED_SEL          <= 4'h0;
            DC_BRAKE_REQUEST   <= 1'b0;
            SECOND_RAMP_SELECT <= 1'b0;
            COAST_STOP         <= 1'b0;
        end else begin
            SPEED_SEL          <= speed_nxt;
            DC_BRAKE_REQUEST   <= brake_req;
            SECOND_RAMP_SELECT <= ramp_req;
            COAST_STOP         <= coast_req;
        end
    end

    // Swapping motor data mid-run would upset the ramp, so the set is
    // frozen until both the command and the motor have stopped.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MOTOR2_SELECT <= 1'b0;
        end else if (!RUN_STATE && !MOTOR_RUNNING) begin
            MOTOR2_SELECT <= motor2_req;
        end
    end

    // Checks below watch the design's own decode against its outputs.

    property p_cfg_write;
        @(posedge CLK) disable iff (SRST)
        (wr_take && AVS_BYTEENABLE[0] &&
         word == OFS_FUNC_BASE[7:2])
        |=> func_r[0] == $past(AVS_WRITEDATA[7:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("Function select write did not land.");

    property p_polarity;
        @(posedge CLK) disable iff (SRST)
        (pol_r[0] == POL_NORMALLY_CLOSED && !level[0] &&
         func_r[0] == FN_COAST_STOP) |=> COAST_STOP;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("Normally closed low input not active.");

    property p_open_code;
        @(posedge CLK) disable iff (SRST)
        (pol_r[0] == POL_NORMALLY_OPEN) |-> act[0] == level[0];
    endproperty
    a_open_code: assert property (p_open_code)
        else $error("Normally open terminal inverted.");

    property p_forward;
        @(posedge CLK) disable iff (SRST)
        (fwd_req && !rev_req) |=> FORWARD_RUN && RUN_STATE;
    endproperty
    a_forward: assert property (p_forward)
        else $error("Forward request did not run forward.");

    property p_reverse;
        @(posedge CLK) disable iff (SRST)
        REVERSE_RUN |-> $past(rev_req) && !FORWARD_RUN;
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("Reverse run without its request.");

    property p_speed;
        @(posedge CLK) disable iff (SRST)
        (act[0] && func_r[0] == FN_SPEED_BIT3) |=> SPEED_SEL[3];
    endproperty
    a_speed: assert property (p_speed)
        else $error("Speed bit three not set.");

    property p_jog;
        @(posedge CLK) disable iff (SRST)
        JOG_RUN |-> RUN_STATE && !FORWARD_RUN && !REVERSE_RUN;
    endproperty
    a_jog: assert property (p_jog)
        else $error("Jog run state inconsistent.");

    property p_stop;
        @(posedge CLK) disable iff (SRST)
        (!fwd_req && !rev_req && !jog_req) |=> !RUN_STATE;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Drive ran with no run request.");

    property p_motor2_hold;
        @(posedge CLK) disable iff (SRST)
        ($past(RUN_STATE) || $past(MOTOR_RUNNING))
        |-> $stable(MOTOR2_SELECT);
    endproperty
    a_motor2_hold: assert property (p_motor2_hold)
        else $error("Motor set changed while running.");

    property p_motor2_take;
        @(posedge CLK) disable iff (SRST)
        (!RUN_STATE && !MOTOR_RUNNING) |=>
        MOTOR2_SELECT == $past(motor2_req);
    endproperty
    a_motor2_take: assert property (p_motor2_take)
        else $error("Motor set not taken while stopped.");

    property p_brake_ramp;
        @(posedge CLK) disable iff (SRST)
        DC_BRAKE_REQUEST == $past(brake_req) &&
        SECOND_RAMP_SELECT == $past(ramp_req);
    endproperty
    a_brake_ramp: assert property (p_brake_ramp)
        else $error("Brake or ramp select without request.");

    property p_coast;
        @(posedge CLK) disable iff (SRST)
        coast_req [*2] |-> COAST_STOP;
    endproperty
    a_coast: assert property (p_coast)
        else $error("Coast stop did not follow its request.");

    property p_no_effect;
        @(posedge CLK) disable iff (SRST)
        !any_known |=> !RUN_STATE && SPEED_SEL == 4'h0 && !COAST_STOP &&
        !DC_BRAKE_REQUEST && !SECOND_RAMP_SELECT;
    endproperty
    a_no_effect: assert property (p_no_effect)
        else $error("Undefined code had an effect.");

    property p_bus_answer;
        @(posedge CLK) disable iff (SRST)
        (req && bus_r == BUS_IDLE) |=> !AVS_WAITREQUEST;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus answer later than one wait cycle.");

    // Main scenarios.
    c_forward: cover property (@(posedge CLK) disable iff (SRST)
        FORWARD_RUN);
    c_motor2: cover property (@(posedge CLK) disable iff (SRST)
        $rose(MOTOR2_SELECT));
    c_speed_all: cover property (@(posedge CLK) disable iff (SRST)
        SPEED_SEL == 4'hf);
    c_write: cover property (@(posedge CLK) disable iff (SRST)
        wr_take);

endmodule

// ===== verif/terminal_switches.sv
// Behavioural bank of contacts that drives the mapper's terminal pins.
`timescale 1ns/10ps
module terminal_switches #(
    parameter int N = 5
) (
    // Clock.
    input  wire logic         clk,
    // Contact commands and bounce mode.
    input  wire logic [N-1:0] closed,
    input  wire logic         slow,
    // Terminal pins.
    output logic      [N-1:0] pins
);
    logic [N-1:0] prev_r = '0;
    logic [1:0]   bnc_r  = 2'h0;

    // A slow contact bounces once, one cycle long, two cycles after a change.
    always @(posedge clk) begin
        prev_r <= closed;
        if (slow && closed != prev_r) begin
            bnc_r <= 2'h2;
        end else if (bnc_r != 2'h0) begin
            bnc_r <= bnc_r - 2'h1;
        end
    end

    // The bounce inverts every pin, so the filter must reject it whole.
    always_comb pins = (bnc_r == 2'h1) ? ~closed : closed;
endmodule

// ===== verif/input_function_mapper_tb_top.sv
// Self-checking testbench of the input function mapper.
`timescale 1ns/10ps
module input_function_mapper_tb_top;
    import input_map_pkg::*;
    localparam logic [7:0] CODES [12] = '{8'h00, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0b, 8'h0a, 8'h12};
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'h1;
    logic [31:0] rdata;
    logic        wait_req;
    logic [4:0]  contact = 5'h0;
    logic [4:0]  pins;
    logic        slow = 1'b0;
    logic        motor_run = 1'b0;
    logic [11:0] cmds;
    logic [7:0]  fn [5];
    logic [1:0]  pl [5];
    logic [32:0] expq [$];
    logic [32:0] e_w;
    int          fails = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    terminal_switches #(.N(5)) sw (.clk(clk), .closed(contact), .slow(slow),
        .pins(pins));

    input_function_mapper #(.N_TERM(5)) dut (
        .CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .TERM_IN(pins),
        .MOTOR_RUNNING(motor_run), .SPEED_SEL(cmds[3:0]),
        .FORWARD_RUN(cmds[4]), .REVERSE_RUN(cmds[5]), .JOG_RUN(cmds[6]),
        .DC_BRAKE_REQUEST(cmds[7]), .MOTOR2_SELECT(cmds[8]),
        .SECOND_RAMP_SELECT(cmds[9]), .COAST_STOP(cmds[10]),
        .RUN_STATE(cmds[11]));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (expq.size() != 0) fails++;
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Each accepted read takes the oldest note; status reads check the command outputs too.
    always @(posedge clk) begin
        if (rd && wait_req === 1'b0) begin
            e_w = expq.pop_front();
            chk(rdata, e_w[31:0]);
            if (e_w[32]) chk({20'h0, cmds}, {20'h0, e_w[27:16]});
        end
    end

    // Waits for waitrequest low under a bound, so a dead slave ends the run.
    task automatic accept_wait;
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        if (n == 20) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] b);
        addr <= a;
        wdata <= {24'($urandom()), d};
        be <= b;
        wr <= 1'b1;
        accept_wait();
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic p);
        expq.push_back({p, e});
        addr <= a;
        rd <= 1'b1;
        accept_wait();
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic set_term(input int i, input logic [7:0] f,
                            input logic [1:0] p);
        fn[i] = f;
        pl[i] = p;
        bus_wr(8'(4 * i), f, {3'($urandom()), 1'b1});
        bus_wr(8'(8'h20 + 4 * i), {6'h0, p}, {3'($urandom()), 1'b1});
    endtask

    // Expected status word from the settings and the settled contacts.
    function automatic logic [31:0] model(input logic m2);
        logic [4:0]  act;
        logic [31:0] s;
        logic        f;
        logic        r;
        logic        j;
        s = 32'h0;
        f = 1'b0;
        r = 1'b0;
        j = 1'b0;
        for (int i = 0; i < 5; i++) begin
            act[i] = contact[i] ^ (pl[i] == POL_NORMALLY_CLOSED);
            if (act[i]) begin
                if (fn[i] == FN_FORWARD_RUN) f = 1'b1;
                if (fn[i] == FN_REVERSE_RUN) r = 1'b1;
                if (fn[i] == FN_JOG_RUN) j = 1'b1;
                if (fn[i] >= FN_SPEED_BIT0 && fn[i] <= FN_SPEED_BIT3)
                    s[ST_SPEED_LSB + 2'(fn[i][1:0] - 2'h2)] = 1'b1;
                if (fn[i] == FN_DC_BRAKE) s[ST_BRAKE_BIT] = 1'b1;
                if (fn[i] == FN_SECOND_RAMP) s[ST_RAMP_BIT] = 1'b1;
                if (fn[i] == FN_COAST_STOP) s[ST_COAST_BIT] = 1'b1;
            end
        end
        s[7:0] = {3'h0, contact};
        s[15:8] = {3'h0, act};
        s[ST_FWD_BIT] = f & ~r;
        s[ST_REV_BIT] = r & ~f;
        s[ST_JOG_BIT] = j & ~f & ~r;
        s[ST_MOTOR2_BIT] = m2;
        s[ST_RUN_BIT] = s[ST_FWD_BIT] | s[ST_REV_BIT] | s[ST_JOG_BIT];
        return s;
    endfunction

    // Five edges reach the outputs; three more cover a bouncing contact.
    task automatic settle_check(input logic m2);
        repeat (8) @(posedge clk);
        bus_rd(OFS_STATUS, model(m2), 1'b1);
    endtask

    initial begin
        void'($urandom(32'h0ece));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            fn[i] = RST_FUNC[i];
            pl[i] = RST_POL;
            bus_rd(8'(4 * i), {24'h0, RST_FUNC[i]}, 1'b0);
            bus_rd(8'(8'h20 + 4 * i), 32'h0, 1'b0);
        end
        bus_rd(8'h60, 32'h0, 1'b0);
        settle_check(1'b0);
        // Writes without the low byte lane, or to status, change nothing.
        bus_wr(8'h00, 8'h33, 4'he);
        bus_wr(OFS_STATUS, 8'hff, 4'h1);
        bus_rd(8'h00, 32'h0, 1'b0);
        settle_check(1'b0);
        // Every code but 08 on terminal 1 under polarity codes 0 to 2, others inert.
        for (int i = 1; i < 5; i++) set_term(i, 8'h0a, 2'h0);
        for (int p = 0; p < 3; p++) begin
            slow <= (p == 1);
            for (int k = 0; k < 12; k++) begin
                set_term(0, CODES[k], 2'(p));
                bus_rd(8'h20, {30'h0, 2'(p)}, 1'b0);
                contact <= 5'h0;
                settle_check(1'b0);
                contact <= 5'h1;
                settle_check(1'b0);
            end
        end
        // Random mixes exercise conflicts and ORed speed bits.
        for (int n = 0; n < 40; n++) begin
            for (int i = 0; i < 5; i++)
                set_term(i, CODES[$urandom_range(11)], 2'($urandom_range(1)));
            contact <= 5'($urandom());
            slow <= 1'($urandom());
            settle_check(1'b0);
        end
        // Motor set choice may change only while fully stopped.
        slow <= 1'b0;
        set_term(0, FN_MOTOR2_SELECT, 2'h0);
        set_term(1, FN_FORWARD_RUN, 2'h0);
        for (int i = 2; i < 5; i++) set_term(i, 8'h0a, 2'h0);
        contact <= 5'h02;
        settle_check(1'b0);
        contact <= 5'h03;
        settle_check(1'b0);
        contact <= 5'h01;
        motor_run <= 1'b1;
        settle_check(1'b0);
        motor_run <= 1'b0;
        settle_check(1'b1);
        // Start running with the set request held, then drop the request.
        contact <= 5'h03;
        settle_check(1'b1);
        contact <= 5'h02;
        settle_check(1'b1);
        contact <= 5'h00;
        settle_check(1'b0);
        end_of_test();
    end
endmodule
